/* cbc_bridge_regs.sv */
`timescale 1ns/1ps
module cbc_bridge_regs (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    // axi4-lite write address
    input wire logic [31:0] S_AXI_AWADDR_I,
    input wire logic S_AXI_AWVALID_I,
    output logic S_AXI_AWREADY_O,
    // axi4-lite write data
    input wire logic [31:0] S_AXI_WDATA_I,
    input wire logic [3:0] S_AXI_WSTRB_I,
    input wire logic S_AXI_WVALID_I,
    output logic S_AXI_WREADY_O,
    // axi4-lite write response
    output logic [1:0] S_AXI_BRESP_O,
    output logic S_AXI_BVALID_O,
    input wire logic S_AXI_BREADY_I,
    // axi4-lite read address
    input wire logic [31:0] S_AXI_ARADDR_I,
    input wire logic S_AXI_ARVALID_I,
    output logic S_AXI_ARREADY_O,
    // axi4-lite read data
    output logic [31:0] S_AXI_RDATA_O,
    output logic [1:0] S_AXI_RRESP_O,
    output logic S_AXI_RVALID_O,
    input wire logic S_AXI_RREADY_I,
    // window and posting controls
    output logic WRITE_POST_EN_O,
    output logic MEM0_PREFETCH_O,
    output logic MEM1_PREFETCH_O,
    // card functional interrupt routing
    input wire logic CARD_IREQ_I,
    output logic PCI_INTA_N_O,
    output logic LEGACY_IRQ_O,
    // card reset
    output logic CRST_N_O,
    // error reporting
    input wire logic CB_MASTER_ABORT_I,
    input wire logic SERR_EN_I,
    input wire logic CSERR_N_I,
    input wire logic CB_PARITY_ERR_I,
    output logic TARGET_ABORT_O,
    output logic SERR_N_O,
    output logic CPERR_N_O,
    // forwarding decode
    input wire logic REQ_VALID_I,
    input wire logic REQ_IS_IO_I,
    input wire logic [31:0] REQ_ADDR_I,
    output logic DEC_VALID_O,
    output logic FWD_VGA_O,
    output logic ISA_BLOCK_O,
    // identification
    output logic [15:0] SSVID_O
);

    // register state
    logic [15:0] bctl_ff;
    logic [15:0] nxt_bctl;
    logic [15:0] ssvid_ff;
    logic [15:0] nxt_ssvid;
    logic lock_ff;
    logic nxt_lock;

    // write channel state
    logic awready_ff;
    logic wready_ff;
    logic aw_held_ff;
    logic w_held_ff;
    logic [31:0] aw_addr_ff;
    logic [31:0] w_data_ff;
    logic [3:0] w_strb_ff;
    logic bvalid_ff;
    logic [1:0] bresp_ff;

    // read channel state
    logic arready_ff;
    logic rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0] rresp_ff;

    // function outputs
    logic inta_n_ff;
    logic legacy_irq_ff;
    logic crst_n_ff;
    logic tabort_ff;
    logic serr_n_ff;
    logic cperr_n_ff;
    logic dec_valid_ff;
    logic fwd_vga_ff;
    logic isa_block_ff;

    // handshakes
    wire aw_take;
    wire w_take;
    wire wr_fire;
    wire b_take;
    wire ar_take;
    wire r_take;
    assign aw_take = S_AXI_AWVALID_I && awready_ff;
    assign w_take = S_AXI_WVALID_I && wready_ff;
    // both halves held and no response outstanding
    assign wr_fire = aw_held_ff && w_held_ff && !bvalid_ff;
    assign b_take = bvalid_ff && S_AXI_BREADY_I;
    assign ar_take = S_AXI_ARVALID_I && arready_ff;
    assign r_take = rvalid_ff && S_AXI_RREADY_I;

    // write decode
    wire wr_bctl;
    wire wr_ssvid;
    wire wr_stat;
    wire wr_mapped;
    wire [15:0] lane_mask;
    assign wr_bctl = aw_addr_ff == cbc_pkg::CBC_BCTL_ADDR;
    assign wr_ssvid = aw_addr_ff == cbc_pkg::CBC_SSVID_ADDR;
    assign wr_stat = aw_addr_ff == cbc_pkg::CBC_STAT_ADDR;
    assign wr_mapped = wr_bctl || wr_ssvid || wr_stat;
    assign lane_mask = {{8{w_strb_ff[1]}}, {8{w_strb_ff[0]}}};

    // bridge control update, fixed-zero bits never take data
    wire [15:0] bctl_wmask;
    assign bctl_wmask = lane_mask & cbc_pkg::CBC_BCTL_WMASK;

    always_comb begin
        nxt_bctl = bctl_ff;
        if (wr_fire && wr_bctl) begin
            nxt_bctl = (bctl_ff & ~bctl_wmask) | (w_data_ff[15:0] & bctl_wmask);
        end
    end

    // a write with no low lane enabled does not spend the single write
    wire ssvid_touch;
    assign ssvid_touch = wr_fire && wr_ssvid && (w_strb_ff[1:0] != 2'h0);

    always_comb begin
        nxt_ssvid = ssvid_ff;
        nxt_lock = lock_ff;
        if (ssvid_touch && !lock_ff) begin
            nxt_ssvid = (ssvid_ff & ~lane_mask) | (w_data_ff[15:0] & lane_mask);
            nxt_lock = 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            bctl_ff <= cbc_pkg::CBC_BCTL_RST;
        end else begin
            bctl_ff <= nxt_bctl;
        end
    end

    // only the bus reset clears the lock
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            ssvid_ff <= cbc_pkg::CBC_SSVID_RST;
            lock_ff <= 1'b0;
        end else begin
            ssvid_ff <= nxt_ssvid;
            lock_ff <= nxt_lock;
        end
    end

    // write address and data are taken independently, in either order
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            awready_ff <= 1'b1;
            aw_held_ff <= 1'b0;
            aw_addr_ff <= 32'h00000000;
        end else if (aw_take) begin
            awready_ff <= 1'b0;
            aw_held_ff <= 1'b1;
            aw_addr_ff <= S_AXI_AWADDR_I;
        end else if (wr_fire) begin
            aw_held_ff <= 1'b0;
        end else if (b_take) begin
            awready_ff <= 1'b1;
        end
    end

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            wready_ff <= 1'b1;
            w_held_ff <= 1'b0;
            w_data_ff <= 32'h00000000;
            w_strb_ff <= 4'h0;
        end else if (w_take) begin
            wready_ff <= 1'b0;
            w_held_ff <= 1'b1;
            w_data_ff <= S_AXI_WDATA_I;
            w_strb_ff <= S_AXI_WSTRB_I;
        end else if (wr_fire) begin
            w_held_ff <= 1'b0;
        end else if (b_take) begin
            wready_ff <= 1'b1;
        end
    end

    // a locked identification write is dropped silently with okay
    wire [1:0] wr_resp;
    assign wr_resp = wr_mapped ? cbc_pkg::CBC_RESP_OKAY : cbc_pkg::CBC_RESP_SLVERR;

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            bvalid_ff <= 1'b0;
            bresp_ff <= cbc_pkg::CBC_RESP_OKAY;
        end else if (wr_fire) begin
            bvalid_ff <= 1'b1;
            bresp_ff <= wr_resp;
        end else if (b_take) begin
            bvalid_ff <= 1'b0;
        end
    end

    // read decode
    wire rd_bctl;
    wire rd_ssvid;
    wire rd_stat;
    wire rd_mapped;
    wire [15:0] stat_word;
    wire [15:0] rd_word;
    assign rd_bctl = S_AXI_ARADDR_I == cbc_pkg::CBC_BCTL_ADDR;
    assign rd_ssvid = S_AXI_ARADDR_I == cbc_pkg::CBC_SSVID_ADDR;
    assign rd_stat = S_AXI_ARADDR_I == cbc_pkg::CBC_STAT_ADDR;
    assign rd_mapped = rd_bctl || rd_ssvid || rd_stat;
    assign stat_word = {14'h0, !crst_n_ff, lock_ff};
    assign rd_word = rd_bctl ? bctl_ff : rd_ssvid ? ssvid_ff : rd_stat ? stat_word : 16'h0000;

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
            rdata_ff <= 32'h00000000;
            rresp_ff <= cbc_pkg::CBC_RESP_OKAY;
        end else if (ar_take) begin
            arready_ff <= 1'b0;
            rvalid_ff <= 1'b1;
            rdata_ff <= {16'h0000, rd_word};
            rresp_ff <= rd_mapped ? cbc_pkg::CBC_RESP_OKAY : cbc_pkg::CBC_RESP_SLVERR;
        end else if (r_take) begin
            arready_ff <= 1'b1;
            rvalid_ff <= 1'b0;
        end
    end

    // interrupt steering
    wire irq_legacy_sel;
    wire irq_to_pci;
    wire irq_to_legacy;
    assign irq_legacy_sel = bctl_ff[cbc_pkg::CBC_B_IRQSEL];
    assign irq_to_pci = CARD_IREQ_I && !irq_legacy_sel;
    assign irq_to_legacy = CARD_IREQ_I && irq_legacy_sel;

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            inta_n_ff <= 1'b1;
            legacy_irq_ff <= 1'b0;
        end else begin
            inta_n_ff <= !irq_to_pci;
            legacy_irq_ff <= irq_to_legacy;
        end
    end

    // the card stays in reset through the whole bus reset
    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            crst_n_ff <= 1'b0;
        end else begin
            crst_n_ff <= !bctl_ff[cbc_pkg::CBC_B_CRST];
        end
    end

    // error reporting
    wire ma_report;
    wire ma_serr;
    wire cserr_fwd;
    wire serr_req;
    wire perr_report;
    assign ma_report = CB_MASTER_ABORT_I && bctl_ff[cbc_pkg::CBC_B_MAMODE];
    assign ma_serr = ma_report && SERR_EN_I;
    assign cserr_fwd = !CSERR_N_I && bctl_ff[cbc_pkg::CBC_B_CSERR];
    assign serr_req = ma_serr || cserr_fwd;
    assign perr_report = CB_PARITY_ERR_I && bctl_ff[cbc_pkg::CBC_B_PERR];

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            tabort_ff <= 1'b0;
            serr_n_ff <= 1'b1;
            cperr_n_ff <= 1'b1;
        end else begin
            tabort_ff <= ma_report;
            serr_n_ff <= !serr_req;
            cperr_n_ff <= !perr_report;
        end
    end

    // forwarding decode
    cbc_dec_if dec_bus ();
    assign dec_bus.addr = REQ_ADDR_I;
    assign dec_bus.is_io = REQ_IS_IO_I;
    assign dec_bus.vga_en = bctl_ff[cbc_pkg::CBC_B_VGA];
    assign dec_bus.isa_en = bctl_ff[cbc_pkg::CBC_B_ISA];

    cbc_fwd_decode u_dec (
        .dec(dec_bus)
    );

    wire vga_fwd_req;
    wire isa_block_req;
    assign vga_fwd_req = REQ_VALID_I && dec_bus.vga_hit;
    assign isa_block_req = REQ_VALID_I && dec_bus.isa_block;

    always_ff @(posedge CLK_I) begin
        if (!RESET_N_I) begin
            dec_valid_ff <= 1'b0;
            fwd_vga_ff <= 1'b0;
            isa_block_ff <= 1'b0;
        end else begin
            dec_valid_ff <= REQ_VALID_I;
            fwd_vga_ff <= vga_fwd_req;
            isa_block_ff <= isa_block_req;
        end
    end

    // outputs
    assign S_AXI_AWREADY_O = awready_ff;
    assign S_AXI_WREADY_O = wready_ff;
    assign S_AXI_BRESP_O = bresp_ff;
    assign S_AXI_BVALID_O = bvalid_ff;
    assign S_AXI_ARREADY_O = arready_ff;
    assign S_AXI_RDATA_O = rdata_ff;
    assign S_AXI_RRESP_O = rresp_ff;
    assign S_AXI_RVALID_O = rvalid_ff;
    assign WRITE_POST_EN_O = bctl_ff[cbc_pkg::CBC_B_WPOST];
    assign MEM0_PREFETCH_O = bctl_ff[cbc_pkg::CBC_B_PF0];
    assign MEM1_PREFETCH_O = bctl_ff[cbc_pkg::CBC_B_PF1];
    assign PCI_INTA_N_O = inta_n_ff;
    assign LEGACY_IRQ_O = legacy_irq_ff;
    assign CRST_N_O = crst_n_ff;
    assign TARGET_ABORT_O = tabort_ff;
    assign SERR_N_O = serr_n_ff;
    assign CPERR_N_O = cperr_n_ff;
    assign DEC_VALID_O = dec_valid_ff;
    assign FWD_VGA_O = fwd_vga_ff;
    assign ISA_BLOCK_O = isa_block_ff;
    assign SSVID_O = ssvid_ff;

endmodule

/* cbc_bridge_regs_asserts.sv */
`timescale 1ns/1ps
module cbc_bridge_regs_asserts (
    // clock and reset
    input wire logic CLK_I,
    input wire logic RESET_N_I,
    // read handshake
    input wire logic S_AXI_ARVALID_I,
    input wire logic S_AXI_ARREADY_O,
    input wire logic S_AXI_RVALID_O,
    // card events and their reports
    input wire logic CARD_IREQ_I,
    input wire logic PCI_INTA_N_O,
    input wire logic LEGACY_IRQ_O,
    input wire logic CRST_N_O,
    input wire logic CB_MASTER_ABORT_I,
    input wire logic SERR_EN_I,
    input wire logic CSERR_N_I,
    input wire logic CB_PARITY_ERR_I,
    input wire logic TARGET_ABORT_O,
    input wire logic SERR_N_O,
    input wire logic CPERR_N_O,
    // forwarding decode
    input wire logic REQ_VALID_I,
    input wire logic REQ_IS_IO_I,
    input wire logic [31:0] REQ_ADDR_I,
    input wire logic DEC_VALID_O,
    input wire logic FWD_VGA_O,
    input wire logic ISA_BLOCK_O,
    // identification
    input wire logic [15:0] SSVID_O
);
    default clocking cb @(posedge CLK_I); endclocking
    default disable iff (!RESET_N_I);
    crst_on_reset_a: assert property (@(posedge CLK_I) disable iff (1'b0) !RESET_N_I |=> !CRST_N_O)
        else $error("card reset not held during bus reset");
    irq_route_a: assert property (CARD_IREQ_I |=> (!PCI_INTA_N_O != LEGACY_IRQ_O))
        else $error("card interrupt not routed to exactly one output");
    irq_idle_a: assert property (!CARD_IREQ_I |=> PCI_INTA_N_O && !LEGACY_IRQ_O)
        else $error("interrupt output without card request");
    tabort_cause_a: assert property (TARGET_ABORT_O |-> $past(CB_MASTER_ABORT_I))
        else $error("target abort without card master abort");
    tabort_serr_a: assert property (TARGET_ABORT_O && $past(SERR_EN_I) |-> !SERR_N_O)
        else $error("enabled system error missing on master abort");
    serr_cause_a: assert property (!SERR_N_O |-> $past(!CSERR_N_I || (CB_MASTER_ABORT_I && SERR_EN_I)))
        else $error("system error without cause");
    cperr_cause_a: assert property (!CPERR_N_O |-> $past(CB_PARITY_ERR_I))
        else $error("parity report without parity error");
    isa_range_a: assert property (REQ_VALID_I && (!REQ_IS_IO_I || REQ_ADDR_I[31:16] != 16'h0 ||
        REQ_ADDR_I[9:8] == 2'h0) |=> DEC_VALID_O && !ISA_BLOCK_O)
        else $error("isa block outside its range");
    vga_io_a: assert property (REQ_VALID_I && REQ_IS_IO_I &&
        !(REQ_ADDR_I inside {[32'h3B0:32'h3BB], [32'h3C0:32'h3DF]}) |=> !FWD_VGA_O)
        else $error("vga forward outside vga io ranges");
    dec_idle_a: assert property (!REQ_VALID_I |=> !DEC_VALID_O && !FWD_VGA_O && !ISA_BLOCK_O)
        else $error("decode result without request");
    ssvid_once_a: assert property ($changed(SSVID_O) |-> $past(SSVID_O) == 16'h0)
        else $error("subsystem vendor changed after first value");
    rd_answer_a: assert property (S_AXI_ARVALID_I && S_AXI_ARREADY_O |=> S_AXI_RVALID_O && !S_AXI_ARREADY_O)
        else $error("read answer not one cycle after address");
    cover property (TARGET_ABORT_O && !SERR_N_O);
    cover property (FWD_VGA_O && ISA_BLOCK_O);
    cover property (LEGACY_IRQ_O);
endmodule
bind cbc_bridge_regs cbc_bridge_regs_asserts u_chk (.*);

/* cbc_card_model.sv */
`timescale 1ns/1ps
module cbc_card_model (
    input wire logic clk_i,
    input wire logic rst_n_i,
    input wire logic [3:0] ev_i,
    output logic ireq_o,
    output logic mabort_o,
    output logic cserr_n_o,
    output logic perr_o
);
    // card events launch one cycle after the bench asks, as a real card would
    always_ff @(posedge clk_i) begin
        if (!rst_n_i) begin
            ireq_o <= 1'b0;
            mabort_o <= 1'b0;
            cserr_n_o <= 1'b1;
            perr_o <= 1'b0;
        end else begin
            ireq_o <= ev_i[0];
            mabort_o <= ev_i[1];
            cserr_n_o <= !ev_i[2];
            perr_o <= ev_i[3];
        end
    end
endmodule

/* cbc_dec_if.sv */
`timescale 1ns/1ps
interface cbc_dec_if;
    logic [31:0] addr;
    logic is_io;
    logic vga_en;
    logic isa_en;
    logic vga_hit;
    logic isa_block;
    modport regs (output addr, output is_io, output vga_en, output isa_en, input vga_hit, input isa_block);
    modport decoder (input addr, input is_io, input vga_en, input isa_en, output vga_hit, output isa_block);
endinterface

/* cbc_fwd_decode.sv */
`timescale 1ns/1ps
module cbc_fwd_decode (
    cbc_dec_if.decoder dec
);
    wire mem_vga;
    wire io_vga0;
    wire io_vga1;
    wire low_page;
    wire upper_part;
    assign mem_vga = !dec.is_io && dec.addr >= cbc_pkg::CBC_VGA_MEM_LO && dec.addr <= cbc_pkg::CBC_VGA_MEM_HI;
    assign io_vga0 = dec.is_io && dec.addr >= cbc_pkg::CBC_VGA_IO0_LO && dec.addr <= cbc_pkg::CBC_VGA_IO0_HI;
    assign io_vga1 = dec.is_io && dec.addr >= cbc_pkg::CBC_VGA_IO1_LO && dec.addr <= cbc_pkg::CBC_VGA_IO1_HI;
    assign dec.vga_hit = dec.vga_en && (mem_vga || io_vga0 || io_vga1);
    // offsets 100h..3FFh of every 1K block are the upper 768 bytes
    assign low_page = dec.addr[31:16] == cbc_pkg::CBC_ISA_PAGE;
    assign upper_part = dec.addr[9:8] != 2'h0;
    assign dec.isa_block = dec.isa_en && dec.is_io && low_page && upper_part;
endmodule

/* cbc_pkg.sv */
package cbc_pkg;
    // printed offsets are register indexes; byte address is four times that
    localparam logic [7:0] CBC_BCTL_IDX = 8'h3E;
    localparam logic [7:0] CBC_SSVID_IDX = 8'h40;
    localparam logic [7:0] CBC_STAT_IDX = 8'h50;
    localparam logic [31:0] CBC_BCTL_ADDR = {22'h0, CBC_BCTL_IDX, 2'h0};
    localparam logic [31:0] CBC_SSVID_ADDR = {22'h0, CBC_SSVID_IDX, 2'h0};
    localparam logic [31:0] CBC_STAT_ADDR = {22'h0, CBC_STAT_IDX, 2'h0};
    // bridge control fields
    localparam int CBC_B_WPOST = 10;
    localparam int CBC_B_PF1 = 9;
    localparam int CBC_B_PF0 = 8;
    localparam int CBC_B_IRQSEL = 7;
    localparam int CBC_B_CRST = 6;
    localparam int CBC_B_MAMODE = 5;
    localparam int CBC_B_VGA = 3;
    localparam int CBC_B_ISA = 2;
    localparam int CBC_B_CSERR = 1;
    localparam int CBC_B_PERR = 0;
    localparam logic [15:0] CBC_BCTL_RST = 16'h0340;
    localparam logic [15:0] CBC_BCTL_WMASK = 16'h07EF;
    localparam logic [15:0] CBC_SSVID_RST = 16'h0000;
    // status fields
    localparam int CBC_S_LOCK = 0;
    localparam int CBC_S_CRST = 1;
    // bus answers
    localparam logic [1:0] CBC_RESP_OKAY = 2'h0;
    localparam logic [1:0] CBC_RESP_SLVERR = 2'h2;
    // forwarding ranges
    localparam logic [31:0] CBC_VGA_MEM_LO = 32'h000A0000;
    localparam logic [31:0] CBC_VGA_MEM_HI = 32'h000BFFFF;
    localparam logic [31:0] CBC_VGA_IO0_LO = 32'h000003B0;
    localparam logic [31:0] CBC_VGA_IO0_HI = 32'h000003BB;
    localparam logic [31:0] CBC_VGA_IO1_LO = 32'h000003C0;
    localparam logic [31:0] CBC_VGA_IO1_HI = 32'h000003DF;
    localparam logic [15:0] CBC_ISA_PAGE = 16'h0000;
endpackage

/* tb_cbc_bridge_regs.sv */
`timescale 1ns/1ps
module tb_cbc_bridge_regs;
    localparam logic [31:0] BC = cbc_pkg::CBC_BCTL_ADDR;
    localparam logic [31:0] SV = cbc_pkg::CBC_SSVID_ADDR;
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rqa = 32'h0, rdata;
    logic [3:0] ws = 4'h0, ev = 4'h0;
    logic awv = 1'b0, wv = 1'b0, br = 1'b0, arv = 1'b0, rr = 1'b0, serr_en = 1'b0, rqv = 1'b0, rqio = 1'b0;
    logic awr, wrdy, bv, arr, rv, ireq, mab, cserr_n, perr, wpe, pf0, pf1, inta_n, lirq, crst_n;
    logic tab, serr_n, cperr_n, decv, fvga, isab;
    logic [1:0] bresp, rresp;
    logic [15:0] ssvid;
    logic [33:0] expq[$];
    logic [32:0] tbl[14] = '{33'h1000003AF, 33'h1000003B0, 33'h1000003BB, 33'h1000003BC, 33'h1000003C0,
        33'h1000003DF, 33'h1000003E0, 33'h1000000FF, 33'h100000100, 33'h100010100, 33'h0000A0000,
        33'h0000BFFFF, 33'h0000C0000, 33'h0000003C4};
    int err_count = 0;
    int checks_done = 0;
    always #10 clk = ~clk;
    cbc_bridge_regs uut (.CLK_I(clk), .RESET_N_I(rst_n), .S_AXI_AWADDR_I(awa), .S_AXI_AWVALID_I(awv),
        .S_AXI_AWREADY_O(awr), .S_AXI_WDATA_I(wd), .S_AXI_WSTRB_I(ws), .S_AXI_WVALID_I(wv), .S_AXI_WREADY_O(wrdy),
        .S_AXI_BRESP_O(bresp), .S_AXI_BVALID_O(bv), .S_AXI_BREADY_I(br), .S_AXI_ARADDR_I(ara),
        .S_AXI_ARVALID_I(arv), .S_AXI_ARREADY_O(arr), .S_AXI_RDATA_O(rdata), .S_AXI_RRESP_O(rresp),
        .S_AXI_RVALID_O(rv), .S_AXI_RREADY_I(rr), .WRITE_POST_EN_O(wpe), .MEM0_PREFETCH_O(pf0),
        .MEM1_PREFETCH_O(pf1), .CARD_IREQ_I(ireq), .PCI_INTA_N_O(inta_n), .LEGACY_IRQ_O(lirq), .CRST_N_O(crst_n),
        .CB_MASTER_ABORT_I(mab), .SERR_EN_I(serr_en), .CSERR_N_I(cserr_n), .CB_PARITY_ERR_I(perr),
        .TARGET_ABORT_O(tab), .SERR_N_O(serr_n), .CPERR_N_O(cperr_n), .REQ_VALID_I(rqv), .REQ_IS_IO_I(rqio),
        .REQ_ADDR_I(rqa), .DEC_VALID_O(decv), .FWD_VGA_O(fvga), .ISA_BLOCK_O(isab), .SSVID_O(ssvid));
    cbc_card_model u_card (.clk_i(clk), .rst_n_i(rst_n), .ev_i(ev), .ireq_o(ireq), .mabort_o(mab),
        .cserr_n_o(cserr_n), .perr_o(perr));
    task automatic chk(input string nm, input logic [33:0] got, input logic [33:0] exp);
        checks_done++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s exp %h got %h", nm, exp, got);
        end
    endtask
    task automatic wrap_up;
        $display("checks %0d mismatches %0d", checks_done, err_count);
        if (err_count == 0 && checks_done > 0) $display("Run complete: PASS");
        else $display("Run complete: FAIL");
        $finish;
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    // master releases each channel only at the edge it is taken
    task automatic axw(input logic [31:0] a, input logic [15:0] d, input logic [3:0] s, input logic [1:0] r);
        int n;
        expq.push_back({r, 32'h0});
        @(posedge clk);
        awa <= a;
        wd <= {16'h0, d};
        ws <= s;
        awv <= 1'b1;
        wv <= 1'b1;
        br <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (awr) awv <= 1'b0;
            if (wrdy) wv <= 1'b0;
            if (bv) break;
        end
        br <= 1'b0;
        if (n == 50) begin err_count++; wrap_up(); end
    endtask
    task automatic axr(input logic [31:0] a, input logic [1:0] r, input logic [15:0] d);
        int n;
        expq.push_back({r, 16'h0, d});
        @(posedge clk);
        ara <= a;
        arv <= 1'b1;
        rr <= 1'b1;
        for (n = 0; n < 50; n++) begin
            @(posedge clk);
            if (arr) arv <= 1'b0;
            if (rv) break;
        end
        rr <= 1'b0;
        if (n == 50) begin err_count++; wrap_up(); end
    endtask
    function automatic logic [1:0] dec_exp(input logic [15:0] b, input logic io, input logic [31:0] a);
        logic v;
        logic i;
        v = b[3] && (io ? ((a >= 32'h3B0 && a <= 32'h3BB) || (a >= 32'h3C0 && a <= 32'h3DF)) :
            (a >= 32'hA0000 && a <= 32'hBFFFF));
        i = b[2] && io && a[31:16] == 16'h0 && a[9:8] != 2'h0;
        return {v, i};
    endfunction
    always @(posedge clk) begin
        if ((rv && rr) || (bv && br)) begin
            if (expq.size() == 0) chk("bus queue", 34'h0, 34'h1);
            else chk(rv ? "read" : "wresp", rv ? {rresp, rdata} : {bresp, 32'h0}, expq.pop_front());
        end
    end
    initial begin
        logic [15:0] v;
        logic [15:0] bc;
        v = 16'($urandom(85));
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        tick(1);
        chk("ctl reset", {30'h0, wpe, pf1, pf0, crst_n}, 34'h6);
        axr(BC, 2'h0, 16'h0340);
        axw(BC, 16'hFFFF, 4'h3, 2'h0);
        axr(BC, 2'h0, 16'h07EF);
        tick(1);
        chk("ctl set", {30'h0, wpe, pf1, pf0, crst_n}, 34'hE);
        axw(BC, 16'h0000, 4'h3, 2'h0);
        tick(2);
        chk("ctl clear", {30'h0, wpe, pf1, pf0, crst_n}, 34'h1);
        repeat (4) begin
            axw(BC, v, 4'h3, 2'h0);
            axr(BC, 2'h0, v & 16'h07EF);
            v = 16'($urandom);
        end
        $display("done register fields");
        @(posedge clk) serr_en <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            axw(BC, i ? 16'h00A3 : 16'h0000, 4'h3, 2'h0);
            @(posedge clk) ev <= 4'hF;
            tick(2);
            chk("irq route", {32'h0, inta_n, lirq}, i ? 34'h3 : 34'h0);
            chk("error report", {31'h0, tab, serr_n, cperr_n}, i ? 34'h4 : 34'h3);
            @(posedge clk) ev <= 4'h0;
        end
        @(posedge clk) serr_en <= 1'b0;
        ev <= 4'h2;
        tick(2);
        chk("abort no serr", {32'h0, tab, serr_n}, 34'h3);
        @(posedge clk) ev <= 4'h4;
        tick(2);
        chk("cserr fwd", {33'h0, serr_n}, 34'h0);
        @(posedge clk) ev <= 4'h0;
        $display("done event routing");
        for (int k = 0; k < 2; k++) begin
            bc = k ? 16'h000C : 16'h0000;
            axw(BC, bc, 4'h3, 2'h0);
            foreach (tbl[j]) begin
                @(posedge clk);
                rqv <= 1'b1;
                rqio <= tbl[j][32];
                rqa <= tbl[j][31:0];
                tick(1);
                chk("decode", {31'h0, decv, fvga, isab}, {32'h1, dec_exp(bc, tbl[j][32], tbl[j][31:0])});
            end
            @(posedge clk) rqv <= 1'b0;
        end
        $display("done decode");
        axw(SV, 16'h1234, 4'h3, 2'h0);
        axw(SV, 16'hBEEF, 4'h3, 2'h0);
        axr(SV, 2'h0, 16'h1234);
        axw(32'h200, 16'h1111, 4'h3, 2'h2);
        axr(32'h204, 2'h2, 16'h0000);
        axr(cbc_pkg::CBC_STAT_ADDR, 2'h0, 16'h0001);
        $display("done vendor lock");
        @(posedge clk) rst_n <= 1'b0;
        tick(2);
        chk("crst in reset", {33'h0, crst_n}, 34'h0);
        @(posedge clk) rst_n <= 1'b1;
        axr(SV, 2'h0, 16'h0000);
        axw(SV, 16'h5A5A, 4'h3, 2'h0);
        axr(SV, 2'h0, 16'h5A5A);
        axr(cbc_pkg::CBC_STAT_ADDR, 2'h0, 16'h0003);
        tick(1);
        chk("ssvid", {18'h0, ssvid}, 34'h5A5A);
        $display("done rearm");
        wrap_up();
    end
endmodule
